// ### rtl/sarcs_pkg.sv
// constants and types shared by the conversion sequencer files
package sarcs_pkg;
    localparam int          SARCS_WIDTH       = 12;
    localparam int          SARCS_IDX_W       = 4;
    localparam logic [11:0] SARCS_RESET_PAT   = 12'h7ff;
    localparam logic [3:0]  SARCS_MSB_IDX     = 4'hb;
    localparam logic [3:0]  SARCS_LSB_IDX     = 4'h0;
    localparam logic        SARCS_DONE_IDLE   = 1'h1;

    typedef enum logic [1:0] {
        SARCS_S_HOLD = 2'h0,
        SARCS_S_CONV = 2'h1,
        SARCS_S_DONE = 2'h3
    } sarcs_state_type;
endpackage

// ### rtl/sarcs_step_if.sv
// step and load strobes between the sequencer and its approximation register
`timescale 1ns/100ps
interface sarcs_step_if;
    logic                                   load;
    logic                                   step;
    logic [sarcs_pkg::SARCS_IDX_W-1:0]      bit_idx;
    logic                                   cmp;
    logic [sarcs_pkg::SARCS_WIDTH-1:0]      result;

    modport ctrl (output load, output step, output bit_idx, output cmp, input result);
    modport regs (input load, input step, input bit_idx, input cmp, output result);
endinterface

// ### rtl/sarcs_approx_reg.sv
// successive approximation register: reset pattern, bit decision and next trial bit
`timescale 1ns/100ps
module sarcs_approx_reg (
    input  wire logic   i_clk,
    input  wire logic   i_reset,
    sarcs_step_if.regs  bus
);
    import sarcs_pkg::*;

    logic [SARCS_WIDTH-1:0] result_q;

    // decided bit takes the comparator, the bit below becomes the trial (low)
    function automatic logic [SARCS_WIDTH-1:0] decide(input logic [SARCS_WIDTH-1:0] q,
                                                      input logic [SARCS_IDX_W-1:0] idx,
                                                      input logic                   cmp);
        logic [SARCS_WIDTH-1:0] n;
        n = q;
        for (int i = 0; i < SARCS_WIDTH; i++) begin
            if (i == int'(idx)) begin
                n[i] = cmp;
            end
            if (i + 1 == int'(idx)) begin
                n[i] = 1'b0; // RULE5
            end
        end
        return n;
    endfunction

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            result_q <= SARCS_RESET_PAT;
        end else if (bus.load) begin
            result_q <= SARCS_RESET_PAT; // RULE1
        end else if (bus.step) begin
            result_q <= decide(result_q, bus.bit_idx, bus.cmp); // RULE4
        end
    end

    assign bus.result = result_q;

    chk_trial_below: assert property (@(posedge i_clk) disable iff (i_reset) // RULE5
        (bus.step && !bus.load && bus.bit_idx != SARCS_LSB_IDX)
        |=> result_q[$past(bus.bit_idx) - 4'h1] == 1'b0)
        else $error("trial bit below decided bit not driven low");
endmodule

// ### rtl/sarcs_sequencer.sv
// conversion sequencer of a 12-bit successive approximation converter
`timescale 1ns/100ps
// What this block does
// RULE1: low start input resets register next edge: msb low, lower bits high.
// RULE2: register holds reset pattern while start stays low; no decisions made.
// RULE3: after start returns high, decisions begin at the following rising edge.
// RULE4: bit under test takes the comparator level, starting with the msb.
// RULE5: same edge that decides a bit drives the next lower bit low.
// RULE6: one decision per rising edge, moving down until lsb is decided.
// RULE7: after lsb decision the active-low done output goes low.
// RULE8: twelve outputs carry complemented binary, msb on top, lsb at bottom.
// RULE9: result and low done hold until start goes low again.
// RULE10: done output stays high throughout a conversion in progress.
// RULE11: controller trusts result outputs only while done is low.
// RULE12: register advances only on rising conversion clock edges, one step each.
// RULE13: start input ignored during conversion; controller syncs start to clock.
// RULE14: done output goes high when the start-driven reset takes effect.
module sarcs_sequencer (
    input  wire logic                           I_CLK,
    input  wire logic                           I_RESET,
    input  wire logic                           I_START_CONVERSION_N,
    input  wire logic                           I_COMPARATOR_OUT,
    output logic [sarcs_pkg::SARCS_WIDTH-1:0]   O_RESULT_BITS,
    output logic                                O_CONVERSION_DONE_N
);
    import sarcs_pkg::*;

    sarcs_state_type        state_q;
    logic [SARCS_IDX_W-1:0] idx_q;
    logic                   done_n_q;
    logic                   start_req;
    logic                   last_step;

    sarcs_step_if step_bus ();

    // start is only honoured outside a conversion
    assign start_req = (state_q != SARCS_S_CONV) && !I_START_CONVERSION_N; // RULE13
    assign last_step = step_bus.step && (idx_q == SARCS_LSB_IDX);

    assign step_bus.load    = start_req; // RULE1 RULE2
    // first decision happens on the first edge that sees start high while holding
    assign step_bus.step    = (state_q == SARCS_S_HOLD && I_START_CONVERSION_N)
                              || state_q == SARCS_S_CONV; // RULE3 RULE12
    assign step_bus.bit_idx = idx_q;
    assign step_bus.cmp     = I_COMPARATOR_OUT;

    sarcs_approx_reg u_reg (
        .i_clk   (I_CLK),
        .i_reset (I_RESET),
        .bus     (step_bus)
    );

    // sequence state
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            state_q <= SARCS_S_HOLD;
        end else begin
            case (state_q)
                SARCS_S_HOLD: begin
                    if (I_START_CONVERSION_N) begin
                        state_q <= SARCS_S_CONV; // RULE3
                    end
                end
                SARCS_S_CONV: begin
                    if (idx_q == SARCS_LSB_IDX) begin
                        state_q <= SARCS_S_DONE; // RULE6
                    end
                end
                SARCS_S_DONE: begin
                    if (!I_START_CONVERSION_N) begin
                        state_q <= SARCS_S_HOLD; // RULE9
                    end
                end
                default: begin
                    state_q <= SARCS_S_HOLD;
                end
            endcase
        end
    end

    // bit pointer walks down one place per edge
    always_ff @(posedge I_CLK) begin
        if (I_RESET || start_req) begin
            idx_q <= SARCS_MSB_IDX;
        end else if (step_bus.step && idx_q != SARCS_LSB_IDX) begin
            idx_q <= idx_q - 4'h1; // RULE6
        end
    end

    // done flag: high from the start-driven reset until the lsb is decided
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            done_n_q <= SARCS_DONE_IDLE;
        end else if (start_req) begin
            done_n_q <= SARCS_DONE_IDLE; // RULE14 RULE10
        end else if (last_step) begin
            done_n_q <= 1'b0; // RULE7
        end
    end

    // the register bits themselves are the complemented code, no inversion needed
    assign O_RESULT_BITS       = step_bus.result; // RULE8
    assign O_CONVERSION_DONE_N = done_n_q;

    // ones on every bit below the given position
    function automatic logic [SARCS_WIDTH-1:0] below_mask(input logic [SARCS_IDX_W-1:0] idx);
        below_mask = (12'h001 << idx) - 12'h001;
    endfunction

    // checker helper: counts decision edges from the msb edge on, independent of the bit pointer
    logic [SARCS_IDX_W-1:0] busy_len_q;

    always_ff @(posedge I_CLK) begin
        if (I_RESET || start_req) begin
            busy_len_q <= 4'h0;
        end else if (state_q == SARCS_S_HOLD && I_START_CONVERSION_N) begin
            busy_len_q <= 4'h1;
        end else if (state_q == SARCS_S_CONV) begin
            busy_len_q <= busy_len_q + 4'h1;
        end
    end

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RESET);

    chk_start_reset: assert property (start_req // RULE1
        |=> O_RESULT_BITS == SARCS_RESET_PAT && O_CONVERSION_DONE_N)
        else $error("start low did not load reset pattern with done high");

    chk_hold_pattern: assert property ((start_req && $past(start_req)) // RULE2
        |-> O_RESULT_BITS == SARCS_RESET_PAT && state_q == SARCS_S_HOLD)
        else $error("register left reset pattern while start held low");

    chk_msb_decide: assert property ((state_q == SARCS_S_HOLD && I_START_CONVERSION_N) // RULE3
        |=> O_RESULT_BITS[11] == $past(I_COMPARATOR_OUT) && O_RESULT_BITS[10:0] == 11'h3ff)
        else $error("msb decision or first trial bit wrong");

    chk_lsb_decide: assert property (last_step // RULE4
        |=> O_RESULT_BITS[0] == $past(I_COMPARATOR_OUT) && !O_CONVERSION_DONE_N)
        else $error("lsb decision or done wrong");

    chk_conv_length: assert property ((state_q == SARCS_S_HOLD && I_START_CONVERSION_N) // RULE6
        |=> O_CONVERSION_DONE_N ##10 O_CONVERSION_DONE_N ##1 !O_CONVERSION_DONE_N)
        else $error("conversion did not take twelve edges");

    chk_done_busy: assert property ((state_q == SARCS_S_CONV) |-> O_CONVERSION_DONE_N) // RULE10
        else $error("done low during conversion");

    chk_result_hold: assert property ((state_q == SARCS_S_DONE && I_START_CONVERSION_N) // RULE9
        |=> $stable(O_RESULT_BITS) && !O_CONVERSION_DONE_N)
        else $error("result or done changed after completion");

    chk_start_ignored: assert property ((state_q == SARCS_S_CONV && idx_q != SARCS_LSB_IDX) // RULE13
        |=> state_q == SARCS_S_CONV && idx_q == $past(idx_q) - 4'h1)
        else $error("conversion disturbed by start input");

    // general forms of the msb and lsb checks, for every decision edge
    chk_bit_decide: assert property (step_bus.step // RULE4
        |=> O_RESULT_BITS[$past(idx_q)] == $past(I_COMPARATOR_OUT))
        else $error("decided bit does not follow the comparator");

    chk_lower_high: assert property ((step_bus.step && idx_q > 4'h1) // RULE5
        |=> (O_RESULT_BITS & below_mask($past(idx_q) - 4'h1)) == below_mask($past(idx_q) - 4'h1))
        else $error("bits below the trial bit not high");

    chk_upper_kept: assert property (step_bus.step // RULE6
        |=> (O_RESULT_BITS & ~below_mask($past(idx_q) + 4'h1))
            == ($past(O_RESULT_BITS) & ~below_mask($past(idx_q) + 4'h1)))
        else $error("bits above the decided bit changed");

    chk_hold_idle: assert property ((state_q == SARCS_S_HOLD && !I_START_CONVERSION_N) // RULE2
        |=> state_q == SARCS_S_HOLD && idx_q == SARCS_MSB_IDX)
        else $error("decision sequence moved while start held low");

    chk_msb_first: assert property ((state_q == SARCS_S_HOLD && I_START_CONVERSION_N) // RULE3
        |-> idx_q == SARCS_MSB_IDX)
        else $error("first decision not at the msb");

    chk_lsb_last: assert property (last_step // RULE6
        |=> state_q == SARCS_S_DONE && idx_q == SARCS_LSB_IDX)
        else $error("sequence did not stop after the lsb");

    chk_busy_len: assert property ($fell(O_CONVERSION_DONE_N) // RULE6
        |-> int'(busy_len_q) == SARCS_WIDTH)
        else $error("done fell after the wrong number of decisions");

    chk_done_state: assert property (!O_CONVERSION_DONE_N // RULE10
        |-> state_q == SARCS_S_DONE)
        else $error("done low outside the completed state");

    chk_no_early_done: assert property ((state_q == SARCS_S_HOLD) // RULE10
        |-> O_CONVERSION_DONE_N)
        else $error("done low while waiting for a conversion");

    chk_done_wait: assert property ((state_q == SARCS_S_DONE && I_START_CONVERSION_N) // RULE9
        |=> state_q == SARCS_S_DONE)
        else $error("completed state left without start low");

    chk_restart: assert property ((state_q == SARCS_S_DONE && !I_START_CONVERSION_N) // RULE14
        |=> state_q == SARCS_S_HOLD && O_CONVERSION_DONE_N)
        else $error("start low after completion did not rearm");

    chk_idx_reload: assert property (start_req // RULE1
        |=> idx_q == SARCS_MSB_IDX)
        else $error("bit pointer not reset to the msb");

    chk_done_rise: assert property ($rose(O_CONVERSION_DONE_N) // RULE14
        |-> $past(start_req) || $past(I_RESET))
        else $error("done rose without a start-driven reset");

    chk_step_edges: assert property (!$stable(O_RESULT_BITS) // RULE12
        |-> $past(step_bus.step) || $past(start_req) || $past(I_RESET))
        else $error("result changed on an edge without a step or load");

    cov_full_conv: cover property (state_q == SARCS_S_CONV ##11 !O_CONVERSION_DONE_N);
    cov_restart: cover property (state_q == SARCS_S_DONE ##1 state_q == SARCS_S_HOLD);
    cov_long_hold: cover property (start_req [*3] ##2 state_q == SARCS_S_CONV);
    cov_start_ignored: cover property (state_q == SARCS_S_CONV && !I_START_CONVERSION_N);
    cov_lsb_set: cover property (last_step && I_COMPARATOR_OUT);
endmodule

// ### verif/sarcs_comparator_model.sv
// comparator stand-in that answers each trial bit from a target code
`timescale 1ns/100ps
module sarcs_comparator_model (
    input  wire logic        i_clk,
    input  wire logic [11:0] i_target,
    input  wire logic [11:0] i_result,
    output logic             o_cmp
);
    // trial bit is the lowest zero; with no trial bit the level means nothing, so it rests low
    always_comb begin
        o_cmp = 1'b0;
        for (int i = 11; i >= 0; i--) begin
            if (i_result[i] === 1'b0) begin
                o_cmp = i_target[i];
            end
        end
    end
endmodule

// ### verif/sarcs_sequencer_tb_top.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module sarcs_sequencer_tb_top;
    import sarcs_pkg::*;
    logic        clk;
    logic        reset;
    logic        start_n;
    logic        cmp;
    logic [11:0] result;
    logic        done_n;
    logic [11:0] target;
    int          n_mismatch;
    int          n_compared;
    sarcs_sequencer u_sarcs_sequencer (.I_CLK(clk), .I_RESET(reset), .I_START_CONVERSION_N(start_n),
        .I_COMPARATOR_OUT(cmp), .O_RESULT_BITS(result), .O_CONVERSION_DONE_N(done_n));
    sarcs_comparator_model u_sarcs_comparator_model (.i_clk(clk), .i_target(target), .i_result(result),
        .o_cmp(cmp));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // start is pulled low for some edges; pattern must appear and stay
    task automatic load(input int hold);
        start_n = 1'b0;
        repeat (hold) begin
            @(negedge clk);
            check({done_n, result}, {1'b1, SARCS_RESET_PAT});
        end
    endtask
    // one conversion; start is pulled low for one edge at glitch_at (1..11) to prove it is ignored
    task automatic convert(input logic [11:0] code, input int glitch_at);
        logic [11:0] hi;
        logic [11:0] exp;
        target = code;
        for (int k = 0; k < 12; k++) begin
            start_n = (k == glitch_at) ? 1'b0 : 1'b1;
            @(negedge clk);
            hi = 12'hfff << (11 - k);
            exp = (code & hi) | (~hi & ~(12'h800 >> (k + 1)));
            check({done_n, result}, {(k < 11), exp});
        end
        start_n = 1'b1;
        repeat (3) begin
            @(negedge clk);
            check({done_n, result}, {1'b0, code});
        end
    endtask
    // reset pulled after a completed conversion with start already high: the msb decision must follow release at once
    task automatic restart_by_reset(input logic [11:0] code);
        reset = 1'b1;
        start_n = 1'b1;
        @(negedge clk);
        check({done_n, result}, {1'b1, SARCS_RESET_PAT});
        reset = 1'b0;
        convert(code, -1);
    endtask
    initial begin
        #8000;
        n_mismatch++;
        $display("Error at %0t: run did not finish", $time);
        conclude();
    end
    initial begin
        reset = 1'b1;
        start_n = 1'b0;
        target = 12'h000;
        n_mismatch = 0;
        n_compared = 0;
        repeat (5) @(negedge clk);
        check({done_n, result}, {1'b1, SARCS_RESET_PAT});
        reset = 1'b0;
        load(3);
        convert(12'h000, -1);
        load(1);
        convert(12'hfff, 5);
        load(1);
        convert(12'haaa, 11);
        load(2);
        convert(12'h555, 1);
        load(1);
        convert(12'h801, -1);
        restart_by_reset(12'h3c5);
        conclude();
    end
endmodule
